// ### logic/cct_core.sv
// Summary of operation
// RQ1 - selected oscillator clock used undivided as system clock
// RQ2 - machine cycle is first then second state
// RQ3 - instruction lasts one, two or three cycles
// RQ4 - port output changes within second state
// RQ5 - port input sampled during first state
// RQ6 - sampled input reaches accumulator next cycle start
// RQ7 - any low during sampling captures zero
// RQ8 - one captured only if high throughout
// RQ9 - interrupt factor sampled, request set first state
// RQ10 - accepted interrupt starts service next machine cycle
// RQ11 - external interrupts select rising, falling or both
// RQ12 - transmit clock pin output as master, input slave
// RQ13 - receive clock pin output as master, input slave
// RQ14 - timer overflow flags drive pins when selected
// RQ15 - reset starts first state, first cycle, no request
`timescale 1ns/1ps
`default_nettype none

module cct_core #(
    parameter int PORT_W = cct_pkg::CCT_PORT_W,
    parameter int NUM_INT = cct_pkg::CCT_NUM_EXT_INT
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // oscillator selection, pin level
    input wire logic i_high_speed_sel,
    output logic o_high_speed_active,
    // instruction sequencing
    input wire logic [1:0] i_instr_cycles,
    output cct_pkg::cct_timing_type o_timing,
    // port access
    input wire cct_pkg::cct_port_req_type i_port_req,
    input wire logic [PORT_W-1:0] i_port_pin,
    output logic [PORT_W-1:0] o_port_out,
    output logic [PORT_W-1:0] o_acc_data,
    output logic o_acc_load,
    // external interrupts
    input wire logic [NUM_INT-1:0] i_ext_interrupt_in,
    input wire logic [2*NUM_INT-1:0] i_int_edge_sel,
    input wire logic i_int_master_en,
    output logic [NUM_INT-1:0] o_irq,
    output logic o_isr_start,
    output logic [1:0] o_isr_vector,
    // synchronous serial clock pins
    input wire logic i_serial_master,
    input wire logic i_tx_clk_gen,
    input wire logic i_rx_clk_gen,
    input wire logic i_serial_tx_clock_pin,
    input wire logic i_serial_rx_clock_pin,
    output cct_pkg::cct_pin_drv_type o_serial_tx_clock_pin,
    output cct_pkg::cct_pin_drv_type o_serial_rx_clock_pin,
    output logic o_tx_clk,
    output logic o_rx_clk,
    // timer overflow flag outputs
    input wire logic i_timer_a_ovf,
    input wire logic i_timer_b_ovf,
    input wire logic [1:0] i_ovf_out_sel,
    output cct_pkg::cct_pin_drv_type o_timer_a_overflow_out,
    output cct_pkg::cct_pin_drv_type o_timer_b_overflow_out
);
    import cct_pkg::*;

    typedef struct packed {
        cct_state_type st;
        logic [1:0] mcyc;
        logic [1:0] ilen;
        logic instr_start;
        logic osc_s1;
        logic osc_s2;
        logic [PORT_W-1:0] pin_s1;
        logic [PORT_W-1:0] pin_s2;
        logic [PORT_W-1:0] pin_prev;
        logic [NUM_INT-1:0] int_s1;
        logic [NUM_INT-1:0] int_s2;
        logic [NUM_INT-1:0] int_prev;
        logic txc_s1;
        logic txc_s2;
        logic rxc_s1;
        logic rxc_s2;
        logic wr_pend;
        logic [PORT_W-1:0] wr_data;
        logic [PORT_W-1:0] port_out;
        logic rd_pend;
        logic cap_valid;
        logic [PORT_W-1:0] cap;
        logic [PORT_W-1:0] acc;
        logic acc_load;
        logic [NUM_INT-1:0] pend;
        logic [NUM_INT-1:0] irq;
        logic isr_go;
        logic [1:0] isr_vec;
        logic isr_start;
        logic txc_o;
        logic txc_oe;
        logic rxc_o;
        logic rxc_oe;
        logic ovf_a;
        logic ovf_a_oe;
        logic ovf_b;
        logic ovf_b_oe;
    } cct_regs_type;

    cct_regs_type r_q;
    cct_regs_type r_d;
    logic [NUM_INT-1:0] edge_hit;

    // edge qualification per external input
    genvar g;
    generate
        for (g = 0; g < NUM_INT; g++) begin : g_edge
            logic rise;
            logic fall;
            logic [1:0] mode;
            assign rise = r_q.int_s2[g] & ~r_q.int_prev[g];
            assign fall = ~r_q.int_s2[g] & r_q.int_prev[g];
            assign mode = i_int_edge_sel[2*g +: 2];
            always_comb begin
                case (mode) // see RQ11
                    CCT_EDGE_RISE: edge_hit[g] = rise;
                    CCT_EDGE_FALL: edge_hit[g] = fall;
                    CCT_EDGE_BOTH: edge_hit[g] = rise | fall;
                    default: edge_hit[g] = 1'b0;
                endcase
            end
        end
    endgenerate

    logic mc_end;
    logic instr_end;
    logic [NUM_INT-1:0] take;
    logic [NUM_INT-1:0] lowest;

    always_comb begin
        r_d = r_q;
        // two flip-flops ahead of every pin
        r_d.osc_s1 = i_high_speed_sel;
        r_d.osc_s2 = r_q.osc_s1;
        r_d.pin_s1 = i_port_pin;
        r_d.pin_s2 = r_q.pin_s1;
        r_d.pin_prev = r_q.pin_s2;
        r_d.int_s1 = i_ext_interrupt_in;
        r_d.int_s2 = r_q.int_s1;
        r_d.int_prev = r_q.int_s2;
        r_d.txc_s1 = i_serial_tx_clock_pin;
        r_d.txc_s2 = r_q.txc_s1;
        r_d.rxc_s1 = i_serial_rx_clock_pin;
        r_d.rxc_s2 = r_q.rxc_s1;

        // one state per system clock, two states per machine cycle
        mc_end = (r_q.st == second_state);
        instr_end = mc_end && (r_q.mcyc >= r_q.ilen);
        r_d.instr_start = 1'b0;
        r_d.acc_load = 1'b0;
        r_d.isr_start = 1'b0;
        case (r_q.st) // see RQ2
            first_state: r_d.st = second_state;
            second_state: r_d.st = first_state;
            default: r_d.st = first_state;
        endcase
        if (instr_end) begin // see RQ3
            r_d.mcyc = CCT_MC_FIRST;
            r_d.instr_start = 1'b1;
            // a zero length is taken as a single cycle instruction
            if (i_instr_cycles == 2'h0) begin
                r_d.ilen = CCT_MC_FIRST;
            end else begin
                r_d.ilen = i_instr_cycles;
            end
        end else if (mc_end) begin
            r_d.mcyc = r_q.mcyc + CCT_MC_FIRST;
        end

        // port write: the new value appears as the second state opens
        if (i_port_req.wr) begin
            r_d.wr_pend = 1'b1;
            r_d.wr_data = i_port_req.wr_data;
        end
        if (r_q.st == first_state && (r_q.wr_pend || i_port_req.wr)) begin // see RQ4
            r_d.port_out = i_port_req.wr ? i_port_req.wr_data : r_q.wr_data;
            r_d.wr_pend = 1'b0;
        end

        // port read: and of every sample taken in the first state
        if (i_port_req.rd) begin
            r_d.rd_pend = 1'b1;
        end
        if (r_q.st == first_state && (r_q.rd_pend || i_port_req.rd)) begin // see RQ5
            // both samples bounding the first state must be high; no glitch filter here
            r_d.cap = (r_q.cap_valid ? r_q.cap : '1) & r_q.pin_s2 & r_q.pin_prev; // see RQ7
            r_d.cap_valid = 1'b1; // see RQ8
            r_d.rd_pend = 1'b0;
        end
        if (mc_end && r_q.cap_valid) begin // see RQ6
            r_d.acc = r_q.cap;
            r_d.acc_load = 1'b1;
            r_d.cap_valid = 1'b0;
        end

        // interrupts: factors caught every edge, request raised in first state
        take = '0;
        lowest = r_q.irq & (~r_q.irq + 1'b1);
        if (i_int_master_en && instr_end && (r_q.irq != '0)) begin // see RQ10
            take = lowest;
            r_d.isr_go = 1'b1;
            r_d.isr_vec = 2'h0;
            for (int i = NUM_INT - 1; i >= 0; i--) begin
                if (lowest[i]) begin
                    r_d.isr_vec = 2'(i);
                end
            end
        end
        if (r_q.isr_go) begin
            r_d.isr_start = 1'b1;
            r_d.isr_go = 1'b0;
        end
        if (r_q.st == first_state) begin // see RQ9
            r_d.irq = (r_q.irq & ~take) | r_q.pend;
            r_d.pend = edge_hit;
        end else begin
            // second state: requests can only clear here, factors can only set
            r_d.irq = r_q.irq & ~take;
            r_d.pend = r_q.pend | edge_hit;
        end

        // serial clocks: drive as master, listen as slave
        r_d.txc_o = i_tx_clk_gen; // see RQ12
        r_d.txc_oe = i_serial_master;
        r_d.rxc_o = i_rx_clk_gen; // see RQ13
        r_d.rxc_oe = i_serial_master;

        // overflow flags onto their pins when the secondary function is chosen
        r_d.ovf_a = i_timer_a_ovf; // see RQ14
        r_d.ovf_a_oe = i_ovf_out_sel[0];
        r_d.ovf_b = i_timer_b_ovf;
        r_d.ovf_b_oe = i_ovf_out_sel[1];
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r_q <= '0;
            r_q.st <= first_state; // see RQ15
            r_q.mcyc <= CCT_MC_FIRST;
            r_q.ilen <= CCT_MC_FIRST;
            r_q.port_out <= CCT_PORT_RST;
            r_q.acc <= CCT_ACC_RST;
            r_q.irq <= CCT_INT_RST;
            r_q.pend <= CCT_INT_RST;
            r_q.isr_vec <= CCT_VEC_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // the clock itself is chosen outside; this only reports the choice
    assign o_high_speed_active = r_q.osc_s2; // see RQ1
    assign o_timing.st = r_q.st;
    assign o_timing.mcyc = r_q.mcyc;
    assign o_timing.instr_start = r_q.instr_start;
    assign o_timing.mcyc_start = (r_q.st == first_state);
    assign o_port_out = r_q.port_out;
    assign o_acc_data = r_q.acc;
    assign o_acc_load = r_q.acc_load;
    assign o_irq = r_q.irq;
    assign o_isr_start = r_q.isr_start;
    assign o_isr_vector = r_q.isr_vec;
    assign o_serial_tx_clock_pin.o = r_q.txc_o;
    assign o_serial_tx_clock_pin.oe = r_q.txc_oe;
    assign o_serial_rx_clock_pin.o = r_q.rxc_o;
    assign o_serial_rx_clock_pin.oe = r_q.rxc_oe;
    // slave clocks come from the pins, master clocks loop back
    assign o_tx_clk = r_q.txc_oe ? r_q.txc_o : r_q.txc_s2;
    assign o_rx_clk = r_q.rxc_oe ? r_q.rxc_o : r_q.rxc_s2;
    assign o_timer_a_overflow_out.o = r_q.ovf_a;
    assign o_timer_a_overflow_out.oe = r_q.ovf_a_oe;
    assign o_timer_b_overflow_out.o = r_q.ovf_b;
    assign o_timer_b_overflow_out.oe = r_q.ovf_b_oe;

endmodule

`default_nettype wire

// ### inc/cct_pkg.sv
package cct_pkg;

    localparam int CCT_PORT_W = 4;
    localparam int CCT_NUM_EXT_INT = 4;

    // machine cycle numbering inside one instruction
    localparam logic [1:0] CCT_MC_FIRST = 2'h1;
    localparam logic [1:0] CCT_MC_SECOND = 2'h2;
    localparam logic [1:0] CCT_MC_THIRD = 2'h3;

    // per-input edge selection
    localparam logic [1:0] CCT_EDGE_OFF = 2'h0;
    localparam logic [1:0] CCT_EDGE_RISE = 2'h1;
    localparam logic [1:0] CCT_EDGE_FALL = 2'h2;
    localparam logic [1:0] CCT_EDGE_BOTH = 2'h3;

    // reset values
    localparam logic [CCT_PORT_W-1:0] CCT_PORT_RST = 4'h0;
    localparam logic [CCT_PORT_W-1:0] CCT_ACC_RST = 4'h0;
    localparam logic [CCT_NUM_EXT_INT-1:0] CCT_INT_RST = 4'h0;
    localparam logic [1:0] CCT_VEC_RST = 2'h0;

    typedef enum logic {
        first_state,
        second_state
    } cct_state_type;

    // port access strobes from the instruction decoder
    typedef struct packed {
        logic wr;
        logic [CCT_PORT_W-1:0] wr_data;
        logic rd;
    } cct_port_req_type;

    // a two-way pin as seen from inside
    typedef struct packed {
        logic o;
        logic oe;
    } cct_pin_drv_type;

    // timing view of the sequencer
    typedef struct packed {
        cct_state_type st;
        logic [1:0] mcyc;
        logic instr_start;
        logic mcyc_start;
    } cct_timing_type;

endpackage

// ### tb/cct_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module cct_pin_model (
    // device side of the serial clock pins
    input wire cct_pkg::cct_pin_drv_type i_tx_drv,
    input wire cct_pkg::cct_pin_drv_type i_rx_drv,
    // levels the far party drives while the device is slave
    input wire logic i_tx_lvl,
    input wire logic i_rx_lvl,
    // resolved wire levels
    output logic o_tx_pin,
    output logic o_rx_pin
);
    import cct_pkg::*;
    // far party backs off whenever the device drives, so no contention
    assign o_tx_pin = i_tx_drv.oe ? i_tx_drv.o : i_tx_lvl;
    assign o_rx_pin = i_rx_drv.oe ? i_rx_drv.o : i_rx_lvl;
endmodule
`default_nettype wire

// ### tb/cct_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cct_core_properties #(
    parameter int PORT_W = 4,
    parameter int NUM_INT = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire cct_pkg::cct_port_req_type i_port_req,
    input wire cct_pkg::cct_timing_type o_timing,
    input wire logic [PORT_W-1:0] o_port_out,
    input wire logic o_acc_load,
    input wire logic i_int_master_en,
    input wire logic [NUM_INT-1:0] o_irq,
    input wire logic o_isr_start,
    input wire logic i_serial_master,
    input wire cct_pkg::cct_pin_drv_type o_serial_tx_clock_pin,
    input wire cct_pkg::cct_pin_drv_type o_serial_rx_clock_pin,
    input wire logic i_timer_a_ovf,
    input wire logic [1:0] i_ovf_out_sel,
    input wire cct_pkg::cct_pin_drv_type o_timer_a_overflow_out
);
    import cct_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    a_state_alt: assert property (1 |=> o_timing.st != $past(o_timing.st))
        else $error("state did not alternate");
    a_cycle_start: assert property (o_timing.mcyc_start == (o_timing.st == first_state))
        else $error("cycle start not in first state");
    a_mcyc_hold: assert property ($changed(o_timing.mcyc) |-> o_timing.st == first_state)
        else $error("cycle number moved inside a cycle");
    a_instr_open: assert property (o_timing.instr_start |-> o_timing.mcyc == CCT_MC_FIRST)
        else $error("instruction opened off first cycle");
    a_port_write: assert property (o_timing.st == first_state && i_port_req.wr
        |=> o_port_out == $past(i_port_req.wr_data)) else $error("port write late or wrong");
    a_port_when: assert property ($changed(o_port_out) |-> o_timing.st == second_state)
        else $error("port changed outside second state");
    a_acc_load: assert property (o_timing.st == first_state && i_port_req.rd
        |-> ##2 o_acc_load && o_timing.st == first_state) else $error("accumulator load late");
    a_irq_set: assert property ((o_irq & ~$past(o_irq)) != '0 |-> o_timing.st == second_state)
        else $error("request set outside first state");
    a_isr_next: assert property (o_isr_start
        |-> o_timing.mcyc == CCT_MC_FIRST && $past(i_int_master_en, 2)) else $error("bad service start");
    a_tx_dir: assert property (1 |=> o_serial_tx_clock_pin.oe == $past(i_serial_master))
        else $error("transmit clock direction wrong");
    a_rx_dir: assert property (1 |=> o_serial_rx_clock_pin.oe == $past(i_serial_master))
        else $error("receive clock direction wrong");
    a_ovf_out: assert property (1 |=> o_timer_a_overflow_out.oe == $past(i_ovf_out_sel[0])
        && (!o_timer_a_overflow_out.oe || o_timer_a_overflow_out.o == $past(i_timer_a_ovf)))
        else $error("overflow pin wrong");
    c_acc: cover property (o_acc_load);
    c_isr: cover property (o_isr_start);
    c_port: cover property ($changed(o_port_out));
endmodule
bind cct_core cct_core_properties #(.PORT_W(PORT_W), .NUM_INT(NUM_INT)) i_chk (.*);
`default_nettype wire

// ### tb/cct_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cct_core_tb_top;
    import cct_pkg::*;
    logic i_sys_clk, i_rstn, hs_sel, hs_act, master, tx_gen, rx_gen, ta, tbo, en, acc_load, isr;
    logic tx_clk, rx_clk, tx_pin, rx_pin, ext_tx, ext_rx;
    logic [1:0] ncyc, ovf_sel, vec;
    logic [3:0] pin, ext, pout, acc, irq;
    logic [7:0] esel;
    cct_port_req_type req;
    cct_timing_type tim;
    cct_pin_drv_type tx_d, rx_d, oa, ob;
    int n_errors, n_checks;
    cct_core i_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_high_speed_sel(hs_sel),
        .o_high_speed_active(hs_act), .i_instr_cycles(ncyc), .o_timing(tim), .i_port_req(req),
        .i_port_pin(pin), .o_port_out(pout), .o_acc_data(acc), .o_acc_load(acc_load),
        .i_ext_interrupt_in(ext), .i_int_edge_sel(esel), .i_int_master_en(en), .o_irq(irq),
        .o_isr_start(isr), .o_isr_vector(vec), .i_serial_master(master), .i_tx_clk_gen(tx_gen),
        .i_rx_clk_gen(rx_gen), .i_serial_tx_clock_pin(tx_pin), .i_serial_rx_clock_pin(rx_pin),
        .o_serial_tx_clock_pin(tx_d), .o_serial_rx_clock_pin(rx_d), .o_tx_clk(tx_clk),
        .o_rx_clk(rx_clk), .i_timer_a_ovf(ta), .i_timer_b_ovf(tbo), .i_ovf_out_sel(ovf_sel),
        .o_timer_a_overflow_out(oa), .o_timer_b_overflow_out(ob));
    cct_pin_model i_far (.i_tx_drv(tx_d), .i_rx_drv(rx_d), .i_tx_lvl(ext_tx), .i_rx_lvl(ext_rx),
        .o_tx_pin(tx_pin), .o_rx_pin(rx_pin));
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask
    task automatic to_first;
        do cyc(1);
        while (tim.st !== first_state);
    endtask
    task automatic wait_start(output int k);
        k = 0;
        do begin
            cyc(1);
            k++;
        end while (tim.instr_start !== 1'b1 && k < 10);
    endtask
    task automatic t_instr(input logic [1:0] n);
        int k;
        ncyc = n;
        repeat (3) wait_start(k);
        chk(8'(k), (n == 2'h0) ? 8'h2 : {5'h0, n, 1'b0});
    endtask
    task automatic t_write(input logic [3:0] d);
        to_first;
        req.wr = 1'b1;
        req.wr_data = d;
        cyc(1);
        req.wr = 1'b0;
        chk({4'h0, pout}, {4'h0, d});
    endtask
    task automatic t_read(input logic [3:0] v, input logic [3:0] lo);
        int k;
        pin = v;
        cyc(4);
        to_first;
        // a one-cycle dip on the cleared bits lands inside the capture interval
        pin = v & lo;
        cyc(1);
        pin = v;
        cyc(1);
        req.rd = 1'b1;
        cyc(1);
        req.rd = 1'b0;
        k = 0;
        while (acc_load !== 1'b1 && k < 6) begin
            cyc(1);
            k++;
        end
        chk({4'h0, acc}, {4'h0, v & lo});
    endtask
    // edges land with the master enable off, so the request must wait for it
    task automatic t_edge(input int g, input logic lvl, input logic exp);
        int k;
        ext[g] = lvl;
        cyc(8);
        chk({7'h0, irq[g]}, {7'h0, exp});
        en = 1'b1;
        k = 0;
        while (exp && isr !== 1'b1 && k < 20) begin
            cyc(1);
            k++;
        end
        if (exp) chk({7'h0, isr}, 8'h1);
        if (exp) chk({6'h0, vec}, 8'(g));
        cyc(2);
        en = 1'b0;
        chk({7'h0, irq[g]}, 8'h0);
    endtask
    task automatic t_serial;
        master = 1'b0;
        ext_tx = 1'b1;
        cyc(4);
        chk({4'h0, tx_clk, rx_clk, tx_d.oe, rx_d.oe}, 8'h8);
        {ext_tx, ext_rx} = 2'h1;
        cyc(4);
        chk({4'h0, tx_clk, rx_clk, tx_d.oe, rx_d.oe}, 8'h4);
        {master, tx_gen} = 2'h3;
        cyc(4);
        chk({2'h0, tx_clk, rx_clk, tx_pin, rx_pin, tx_d.oe, rx_d.oe}, 8'h2b);
    endtask
    task automatic t_misc;
        {hs_sel, ta, ovf_sel} = 4'hf;
        cyc(4);
        chk({3'h0, hs_act, oa.o, oa.oe, ob.o, ob.oe}, 8'h1d);
        {tbo, ovf_sel} = 3'h5;
        cyc(4);
        chk({3'h0, hs_act, oa.o, oa.oe, ob.o, ob.oe}, 8'h1e);
    endtask
    initial begin
        {i_rstn, hs_sel, master, tx_gen, rx_gen, ta, tbo, en, ext_tx, ext_rx} = '0;
        {ncyc, ovf_sel, pin, ext, esel, req} = '0;
        cyc(8);
        chk({tim.st, tim.mcyc, irq, isr}, {first_state, CCT_MC_FIRST, 5'h0});
        i_rstn = 1'b1;
        cyc(1);
        chk({7'h0, tim.st}, {7'h0, second_state});
        for (int n = 0; n < 4; n++) t_instr(2'(n));
        t_write(4'ha);
        t_write(4'h5);
        t_read(4'h9, 4'hf);
        t_read(4'h6, 4'hf);
        t_read(4'hf, 4'h5);
        ncyc = 2'h1;
        for (int g = 0; g < 4; g++) begin
            esel[2*g+:2] = 2'(g);
            t_edge(g, 1'b1, g == 1 || g == 3);
            t_edge(g, 1'b0, g == 2 || g == 3);
        end
        t_serial;
        t_misc;
        results;
    end
    // whole sequence needs well under 20 us
    initial begin
        #100us;
        n_errors++;
        results;
    end
endmodule
`default_nettype wire
